// ===== tb/sab_codec_model.sv
`timescale 1ns/1ns
`default_nettype none
module sab_codec_model (
	input wire logic clkLink,
	input wire logic txData,
	input wire logic txDataOe,
	output logic rxDataIn,
	output logic fsrIn,
	output logic fsxIn,
	output logic [15:0] capWord,
	output int capBits
);
	logic busy;
	initial begin
		busy = 1'b0;
		rxDataIn = 1'b0;
		fsrIn = 1'b0;
		fsxIn = 1'b0;
		capWord = 16'h0000;
		capBits = 0;
	end
	// Idle line keeps changing so no stale bit passes
	always @(negedge clkLink) begin
		if (!busy) rxDataIn <= ~rxDataIn;
		if (txDataOe === 1'b1) begin
			capWord <= {capWord[14:0], txData};
			capBits <= capBits + 1;
		end
	end
	task automatic send(input logic [15:0] w, input int len);
		@(negedge clkLink);
		busy = 1'b1;
		capWord = 16'h0000;
		capBits = 0;
		fsrIn <= 1'b1;
		fsxIn <= 1'b1;
		for (int b = len - 1; b >= 0; b--) begin
			@(negedge clkLink);
			fsrIn <= 1'b0;
			fsxIn <= 1'b0;
			rxDataIn <= w[b];
		end
		@(negedge clkLink);
		busy = 1'b0;
		rxDataIn <= ~w[0];
		repeat (len + 8) @(negedge clkLink);
	endtask
endmodule
`default_nettype wire

// ===== tb/sab_port_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "sab_defines.svh"
module sab_port_asserts (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clkLink,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regRdata,
	input wire logic txDataOe,
	input wire logic bitClkOut,
	input wire logic bitClkOe,
	input wire logic transmitInterrupt,
	input wire logic receiveInterrupt
);
	logic [8:0] ctlReg;
	logic [7:0] divReg;
	logic [7:0] frmReg;
	// Shadow copies of written configuration
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctlReg <= `SAB_CTRL_RST;
			divReg <= `SAB_CLKDIV_RST;
			frmReg <= `SAB_FRAME_RST;
		end else if (regWrite) begin
			if (regAddr == `SAB_REG_CTRL) ctlReg <= regWdata[8:0];
			if (regAddr == `SAB_REG_CLKDIV) divReg <= regWdata[7:0];
			if (regAddr == `SAB_REG_FRAME) frmReg <= regWdata[7:0];
		end
	end
	sequence sRd(logic [7:0] a);
		regRead && regAddr == a;
	endsequence
	sequence sQuiet;
		$stable(ctlReg) ##1 $stable(ctlReg);
	endsequence
	AST_RD_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!regRead |=> regRdata == 16'h0000) else $error("read data not zero when idle");
	AST_RD_CTRL: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sRd(`SAB_REG_CTRL) |=> regRdata == {7'h00, ctlReg}) else $error("control read wrong");
	AST_RD_DIV: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sRd(`SAB_REG_CLKDIV) |=> regRdata == {8'h00, divReg}) else $error("divider read wrong");
	AST_RD_FRM: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sRd(`SAB_REG_FRAME) |=> regRdata == {8'h00, frmReg}) else $error("frame read wrong");
	AST_CLK_OE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sQuiet |-> bitClkOe == ctlReg[`SAB_CTRL_CLKINT] &&
		(ctlReg[`SAB_CTRL_CLKINT] || bitClkOut == ctlReg[`SAB_CTRL_CLKPOL]))
		else $error("bit clock enable wrong");
	AST_CLK_RATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		divReg != 8'h00 && $stable(divReg) && $stable(ctlReg) && $changed(bitClkOut)
		|=> $stable(bitClkOut)) else $error("bit clock too fast");
	AST_TXI_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		transmitInterrupt |=> !transmitInterrupt) else $error("transmit pulse too long");
	AST_RXI_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		receiveInterrupt |=> !receiveInterrupt) else $error("receive pulse too long");
	AST_OE_LEN: assert property (@(posedge clkLink) disable iff (!rst_n)
		$rose(txDataOe) |-> txDataOe [*8]) else $error("transmit word too short");
endmodule
bind sab_port sab_port_asserts i_sab_port_asserts (.clk_sys(clk_sys), .rst_n(rst_n),
	.clkLink(clkLink), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
	.regRead(regRead), .regRdata(regRdata), .txDataOe(txDataOe), .bitClkOut(bitClkOut),
	.bitClkOe(bitClkOe), .transmitInterrupt(transmitInterrupt),
	.receiveInterrupt(receiveInterrupt));
`default_nettype wire

// ===== tb/tb_sab_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "sab_defines.svh"
module tb_sab_port;
	logic clk_sys, rst_n, clkLink, regWrite, regRead, txData, txDataOe, fsxOut, fsxOe;
	logic bitClkOut, bitClkOe, txInt, rxInt, rxDataIn, fsrIn, fsxIn, p;
	logic [7:0] regAddr;
	logic [15:0] regWdata, regRdata, capWord, d, w, e;
	int capBits, n_fail, n_tests, nTx, nRx, i, k, len;
	sab_port i_sab_port (.clk_sys(clk_sys), .rst_n(rst_n), .clkLink(clkLink),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .rxDataIn(rxDataIn), .fsrIn(fsrIn), .fsxIn(fsxIn),
		.txData(txData), .txDataOe(txDataOe), .fsxOut(fsxOut), .fsxOe(fsxOe),
		.bitClkOut(bitClkOut), .bitClkOe(bitClkOe), .transmitInterrupt(txInt),
		.receiveInterrupt(rxInt));
	sab_codec_model i_sab_codec_model (.clkLink(clkLink), .txData(txData),
		.txDataOe(txDataOe), .rxDataIn(rxDataIn), .fsrIn(fsrIn), .fsxIn(fsxIn),
		.capWord(capWord), .capBits(capBits));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		clkLink = 1'b0;
		#7;
		forever #32 clkLink = ~clkLink;
	end
	always @(posedge clk_sys) begin
		nTx += (txInt === 1'b1);
		nRx += (rxInt === 1'b1);
	end
	task chk(input string nm, input logic [15:0] s, input logic [15:0] x);
		n_tests++;
		if (s !== x) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, x, s);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= v;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask
	task rc(input string nm, input logic [7:0] a, input logic [15:0] x);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		@(negedge clk_sys);
		chk(nm, regRdata, x);
	endtask
	task lw(input int n);
		repeat (n) @(posedge clkLink);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk_sys);
		n_fail++;
		tally_and_finish;
	end
	initial begin
		rst_n = 1'b0;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 16'h0000;
		{n_fail, n_tests, nTx, nRx} = '0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		rc("ctrl", `SAB_REG_CTRL, 16'h0000);
		rc("ext", `SAB_REG_EXT, 16'h0000);
		rc("txlen", `SAB_REG_TXLEN, 16'h0001);
		rc("rxstart", `SAB_REG_RXSTART, 16'h0000);
		rc("clkdiv", `SAB_REG_CLKDIV, 16'h0001);
		rc("frame", `SAB_REG_FRAME, 16'h001f);
		rc("unmapped", 8'h3f, 16'h0000);
		wr(`SAB_REG_MADDR, 16'h07fe);
		wr(`SAB_REG_MDATA, 16'h5a5a);
		wr(`SAB_REG_MDATA, 16'ha5c3);
		wr(`SAB_REG_MADDR, 16'h07fe);
		rc("mem0", `SAB_REG_MDATA, 16'h5a5a);
		rc("mem1", `SAB_REG_MDATA, 16'ha5c3);
		// Software-driven words at every packet length
		for (k = 0; k < 4; k++) begin
			len = 8 + 2 * k + (k == 3 ? 2 : 0);
			w = 16'hb2c5 >> (16 - len);
			e = w;
			for (i = len; i < 16; i++) e[i] = w[len - 1];
			wr(`SAB_REG_CTRL, 16'(k << 2));
			lw(6);
			wr(`SAB_REG_TXDATA, 16'(16'h3c96 + k));
			wr(`SAB_REG_CTRL, 16'(3 + (k << 2)));
			lw(6);
			i_sab_codec_model.send(w, len);
			for (i = 0; i < 400 && nRx < k + 1; i++) @(posedge clk_sys);
			chk("rxint", 16'(nRx), 16'(k + 1));
			chk("txint", 16'(nTx), 16'(k + 1));
			chk("txbits", 16'(capBits), 16'(len));
			chk("txword", capWord, 16'((16'h3c96 + k) & ((32'h1 << len) - 1)));
			rc("rxdata", `SAB_REG_RXDATA, e);
		end
		wr(`SAB_REG_CTRL, 16'h000c);
		lw(6);
		wr(`SAB_REG_TXDATA, 16'h8123);
		wr(`SAB_REG_CTRL, 16'h010d);
		lw(6);
		i_sab_codec_model.send(16'h0000, 16);
		chk("pcmbits", 16'(capBits), 16'h0000);
		wr(`SAB_REG_CTRL, 16'h000c);
		wr(`SAB_REG_MADDR, 16'h0200);
		wr(`SAB_REG_MDATA, 16'h1111);
		wr(`SAB_REG_MDATA, 16'h2222);
		wr(`SAB_REG_TXSTART, 16'h0200);
		wr(`SAB_REG_TXLEN, 16'h0002);
		k = nTx;
		wr(`SAB_REG_EXT, 16'h0005);
		lw(6);
		wr(`SAB_REG_CTRL, 16'h000d);
		lw(6);
		i_sab_codec_model.send(16'h0000, 16);
		chk("abutx0", capWord, 16'h1111);
		i_sab_codec_model.send(16'h0000, 16);
		chk("abutx1", capWord, 16'h2222);
		chk("abutxint", 16'(nTx - k), 16'h0002);
		rc("autodis", `SAB_REG_EXT, 16'h0004);
		wr(`SAB_REG_CTRL, 16'h000c);
		wr(`SAB_REG_EXT, 16'h0000);
		wr(`SAB_REG_RXSTART, 16'h0100);
		wr(`SAB_REG_RXLEN, 16'h0004);
		wr(`SAB_REG_EXT, 16'h0002);
		lw(6);
		wr(`SAB_REG_CTRL, 16'h000e);
		lw(6);
		k = nRx;
		for (i = 0; i < 5; i++) i_sab_codec_model.send(16'(16'h7000 + i), 16);
		chk("aburxint", 16'(nRx - k), 16'h0002);
		rc("rxlock", `SAB_REG_RXDATA, 16'h0000);
		wr(`SAB_REG_MADDR, 16'h0100);
		rc("wrap", `SAB_REG_MDATA, 16'h7004);
		rc("mem101", `SAB_REG_MDATA, 16'h7001);
		wr(`SAB_REG_CTRL, 16'h000c);
		wr(`SAB_REG_CLKDIV, 16'h0002);
		wr(`SAB_REG_CTRL, 16'h0030);
		lw(8);
		chk("clkoe", {15'h0000, bitClkOe}, 16'h0001);
		chk("fsoe", {15'h0000, fsxOe}, 16'h0001);
		// Rising edges counted over whole periods
		d = 16'h0000;
		@(negedge clkLink);
		p = fsxOut;
		repeat (96) begin
			@(negedge clkLink);
			d += 16'(fsxOut & ~p);
			p = fsxOut;
		end
		chk("fsrate", d, 16'h0003);
		d = 16'h0000;
		@(negedge clk_sys);
		p = bitClkOut;
		repeat (60) begin
			@(negedge clk_sys);
			d += 16'(bitClkOut & ~p);
			p = bitClkOut;
		end
		chk("clkrate", d, 16'h000a);
		wr(`SAB_REG_CTRL, 16'h0000);
		tally_and_finish;
	end
endmodule
`default_nettype wire

// ===== verilog/sab_defines.svh
`ifndef SAB_DEFINES_SVH
`define SAB_DEFINES_SVH
`define SAB_REG_RXDATA 8'h00
`define SAB_REG_TXDATA 8'h01
`define SAB_REG_CTRL 8'h02
`define SAB_REG_EXT 8'h03
`define SAB_REG_TXSTART 8'h04
`define SAB_REG_TXLEN 8'h05
`define SAB_REG_RXSTART 8'h06
`define SAB_REG_RXLEN 8'h07
`define SAB_REG_STATUS 8'h08
`define SAB_REG_MADDR 8'h09
`define SAB_REG_MDATA 8'h0a
`define SAB_REG_CLKDIV 8'h0b
`define SAB_REG_FRAME 8'h0c
`define SAB_CTRL_TXEN 0
`define SAB_CTRL_RXEN 1
`define SAB_CTRL_LEN 2
`define SAB_CTRL_FSINT 4
`define SAB_CTRL_CLKINT 5
`define SAB_CTRL_FSPOL 6
`define SAB_CTRL_CLKPOL 7
`define SAB_CTRL_PCM 8
`define SAB_CTRL_W 9
`define SAB_EXT_ABUTX 0
`define SAB_EXT_ABURX 1
`define SAB_EXT_ADTX 2
`define SAB_EXT_ADRX 3
`define SAB_EXT_W 4
`define SAB_BITS_8 5'h08
`define SAB_BITS_10 5'h0a
`define SAB_BITS_12 5'h0c
`define SAB_BITS_16 5'h10
`define SAB_MEM_WORDS 2048
`define SAB_CTRL_RST 9'h000
`define SAB_EXT_RST 4'h0
`define SAB_CLKDIV_RST 8'h01
`define SAB_FRAME_RST 8'h1f
`define SAB_LEN_RST 12'h001
`define SAB_LEN_MAX 12'h800
`endif

// ===== verilog/sab_link.sv
`timescale 1ns/1ns
`default_nettype none
`include "sab_defines.svh"
module sab_link (
	input wire logic clkLink,
	input wire logic rst_n,
	input wire logic [1:0] cfgLen,
	input wire logic cfgTxEn,
	input wire logic cfgRxEn,
	input wire logic cfgFsInt,
	input wire logic cfgFsPol,
	input wire logic cfgPcm,
	input wire logic [7:0] cfgFrame,
	input wire logic txReqTgl,
	input wire logic [15:0] txWord,
	output logic txAckTgl,
	output logic rxTgl,
	output logic [15:0] rxWord,
	input wire logic fsxIn,
	input wire logic fsrIn,
	input wire logic rxDataIn,
	output logic txData,
	output logic txDataOe,
	output logic fsxOut,
	output logic fsxOe
);
	function automatic logic [4:0] lenBits(input logic [1:0] code);
		case (code)
			sab_pkg::SAB_LEN_8: lenBits = `SAB_BITS_8;
			sab_pkg::SAB_LEN_10: lenBits = `SAB_BITS_10;
			sab_pkg::SAB_LEN_12: lenBits = `SAB_BITS_12;
			default: lenBits = `SAB_BITS_16;
		endcase
	endfunction
	function automatic sab_pkg::sab_word_t signExt(input sab_pkg::sab_word_t raw,
		input logic [1:0] code);
		case (code)
			sab_pkg::SAB_LEN_8: signExt = {{8{raw[7]}}, raw[7:0]};
			sab_pkg::SAB_LEN_10: signExt = {{6{raw[9]}}, raw[9:0]};
			sab_pkg::SAB_LEN_12: signExt = {{4{raw[11]}}, raw[11:0]};
			default: signExt = raw;
		endcase
	endfunction
	logic [18:0] syncIn;
	logic [18:0] syncA;
	logic [18:0] syncB;
	assign syncIn = {rxDataIn, fsrIn, fsxIn, txReqTgl, cfgFrame, cfgPcm, cfgFsPol, cfgFsInt,
		cfgRxEn, cfgTxEn, cfgLen};
	genvar g;
	generate
		for (g = 0; g < 19; g++) begin : gSync
			always_ff @(posedge clkLink or negedge rst_n) begin
				if (!rst_n) begin
					syncA[g] <= 1'b0;
					syncB[g] <= 1'b0;
				end else begin
					syncA[g] <= syncIn[g];
					syncB[g] <= syncA[g];
				end
			end
		end
	endgenerate
	logic [1:0] lenCode;
	logic [4:0] nBits;
	logic fsIntS;
	logic fsPolS;
	logic reqS;
	logic fsxLvl;
	logic fsrLvl;
	logic fsxPrev;
	logic fsrPrev;
	logic fsGen;
	logic [7:0] frameCnt;
	logic startTx;
	logic startRx;
	assign lenCode = syncB[1:0];
	assign nBits = lenBits(lenCode);
	assign fsIntS = syncB[4];
	assign fsPolS = syncB[5];
	assign reqS = syncB[15];
	assign fsxLvl = syncB[16] ^ fsPolS;
	assign fsrLvl = syncB[17] ^ fsPolS;
	assign startTx = fsIntS ? fsGen : (fsxLvl & ~fsxPrev);
	assign startRx = fsIntS ? fsGen : (fsrLvl & ~fsrPrev);
	assign fsxOe = fsIntS;
	// Internal frame pulse once per programmed frame period
	always_ff @(posedge clkLink or negedge rst_n) begin
		if (!rst_n) begin
			frameCnt <= 8'h00;
			fsGen <= 1'b0;
			fsxOut <= 1'b0;
			fsxPrev <= 1'b0;
			fsrPrev <= 1'b0;
		end else begin
			fsxPrev <= fsxLvl;
			fsrPrev <= fsrLvl;
			if (!fsIntS) begin
				frameCnt <= 8'h00;
				fsGen <= 1'b0;
			end else if (frameCnt == syncB[14:7]) begin
				frameCnt <= 8'h00;
				fsGen <= 1'b1;
			end else begin
				frameCnt <= frameCnt + 8'h01;
				fsGen <= 1'b0;
			end
			fsxOut <= (fsIntS & (frameCnt == syncB[14:7])) ^ fsPolS;
		end
	end
	sab_pkg::sab_shift_e txState;
	sab_pkg::sab_word_t pendWord;
	sab_pkg::sab_word_t lastWord;
	sab_pkg::sab_word_t txShift;
	sab_pkg::sab_word_t txSrc;
	logic pendValid;
	logic reqPrev;
	logic loadNow;
	logic takeReq;
	logic pcmIdle;
	logic [4:0] txCnt;
	assign loadNow = startTx & syncB[2];
	assign takeReq = (reqS != reqPrev) & (~pendValid | loadNow);
	assign txSrc = pendValid ? pendWord : lastWord;
	assign txAckTgl = reqPrev;
	// Second stage of transmit double buffer
	always_ff @(posedge clkLink or negedge rst_n) begin
		if (!rst_n) begin
			pendWord <= 16'h0000;
			pendValid <= 1'b0;
			reqPrev <= 1'b0;
			lastWord <= 16'h0000;
		end else begin
			if (loadNow) begin
				lastWord <= txSrc;
			end
			if (takeReq) begin
				pendWord <= txWord;
				pendValid <= 1'b1;
				reqPrev <= reqS;
			end else if (loadNow) begin
				pendValid <= 1'b0;
			end
		end
	end
	// Frame during a word aborts it and reloads
	always_ff @(posedge clkLink or negedge rst_n) begin
		if (!rst_n) begin
			txState <= sab_pkg::SAB_IDLE;
			txShift <= 16'h0000;
			txCnt <= 5'h00;
			txData <= 1'b0;
			txDataOe <= 1'b0;
			pcmIdle <= 1'b0;
		end else if (loadNow) begin
			txState <= sab_pkg::SAB_SHIFT;
			txShift <= txSrc << (5'h10 - nBits);
			txCnt <= nBits;
			pcmIdle <= syncB[6] & txSrc[15];
			txDataOe <= 1'b0;
		end else begin
			case (txState)
				sab_pkg::SAB_SHIFT: begin
					if (txCnt == 5'h00) begin
						txState <= sab_pkg::SAB_IDLE;
						txDataOe <= 1'b0;
					end else begin
						txData <= txShift[15];
						txDataOe <= ~pcmIdle;
						txShift <= {txShift[14:0], 1'b0};
						txCnt <= txCnt - 5'h01;
					end
				end
				default: begin
					txDataOe <= 1'b0;
				end
			endcase
		end
	end
	sab_pkg::sab_shift_e rxState;
	sab_pkg::sab_word_t rxShift;
	logic [4:0] rxCnt;
	always_ff @(posedge clkLink or negedge rst_n) begin
		if (!rst_n) begin
			rxState <= sab_pkg::SAB_IDLE;
			rxShift <= 16'h0000;
			rxCnt <= 5'h00;
			rxWord <= 16'h0000;
			rxTgl <= 1'b0;
		end else if (startRx & syncB[3]) begin
			rxState <= sab_pkg::SAB_SHIFT;
			rxShift <= 16'h0000;
			rxCnt <= nBits;
		end else begin
			case (rxState)
				sab_pkg::SAB_SHIFT: begin
					rxShift <= {rxShift[14:0], syncB[18]};
					rxCnt <= rxCnt - 5'h01;
					if (rxCnt == 5'h01) begin
						rxWord <= signExt({rxShift[14:0], syncB[18]}, lenCode);
						rxTgl <= ~rxTgl;
						rxState <= sab_pkg::SAB_IDLE;
					end
				end
				default: begin
					rxCnt <= 5'h00;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== verilog/sab_pkg.sv
package sab_pkg;
	typedef logic [15:0] sab_word_t;
	typedef logic [10:0] sab_addr_t;
	typedef logic [11:0] sab_len_t;
	typedef enum logic [1:0] {SAB_LEN_8, SAB_LEN_10, SAB_LEN_12, SAB_LEN_16} sab_len_e;
	typedef enum logic {SAB_IDLE, SAB_SHIFT} sab_shift_e;
endpackage

// ===== verilog/sab_port.sv
// Functional notes
// - Transmit and receive run at once, each double-buffered behind its shift register.
// - Packet length selects 8, 10, 12 or 16 bits; both ends agree.
// - Optional internal frame sync and programmable-rate bit clock.
// - Frame sync and bit clock polarity each selectable.
// - Serial bit rate never above the master clock rate.
// - Transmit offers a PCM line mode besides normal sending.
// - Autobuffer unit owns circular address generators, moves words without CPU.
// - Autobuffers live only inside the dedicated 2K-word memory block.
// - The dedicated block stays usable by the CPU as plain storage.
// - Software programs start address and length of each autobuffer.
// - Auto-disable stops buffering by itself; half/full buffer interrupts raised.
// - Autobuffering enabled separately for transmit and receive.
// - Without autobuffering, software moves words and the unit stays out.
// - Non-buffered mode gives one interrupt per transmitted or received word.
// - Buffered mode interrupts only at each half of the buffer.
// - Received 8, 10 and 12 bit words are sign-extended to 16 bits.
// - Data register read/write accepted only while that direction is unbuffered.
`timescale 1ns/1ns
`default_nettype none
`include "sab_defines.svh"
module sab_port (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clkLink,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [15:0] regRdata,
	input wire logic rxDataIn,
	input wire logic fsrIn,
	input wire logic fsxIn,
	output logic txData,
	output logic txDataOe,
	output logic fsxOut,
	output logic fsxOe,
	output logic bitClkOut,
	output logic bitClkOe,
	output logic transmitInterrupt,
	output logic receiveInterrupt
);
	function automatic sab_pkg::sab_len_t lenEff(input sab_pkg::sab_len_t len);
		if (len == 12'h000) begin
			lenEff = `SAB_LEN_RST;
		end else if (len > `SAB_LEN_MAX) begin
			lenEff = `SAB_LEN_MAX;
		end else begin
			lenEff = len;
		end
	endfunction
	logic [`SAB_CTRL_W-1:0] ctrlReg;
	logic [`SAB_EXT_W-1:0] extReg;
	sab_pkg::sab_addr_t txStartReg;
	sab_pkg::sab_addr_t rxStartReg;
	sab_pkg::sab_len_t txLenReg;
	sab_pkg::sab_len_t rxLenReg;
	logic [7:0] clkDivReg;
	logic [7:0] frameReg;
	sab_pkg::sab_addr_t memAddrReg;
	sab_pkg::sab_word_t mem [0:`SAB_MEM_WORDS-1];
	logic abuTx;
	logic abuRx;
	logic wrTxData;
	logic rdRxData;
	logic cpuMemWr;
	logic cpuMemRd;
	assign abuTx = extReg[`SAB_EXT_ABUTX];
	assign abuRx = extReg[`SAB_EXT_ABURX];
	assign wrTxData = regWrite && (regAddr == `SAB_REG_TXDATA) && !abuTx;
	assign rdRxData = regRead && (regAddr == `SAB_REG_RXDATA) && !abuRx;
	assign cpuMemWr = regWrite && (regAddr == `SAB_REG_MDATA);
	assign cpuMemRd = regRead && (regAddr == `SAB_REG_MDATA);
	logic linkAck;
	logic linkRxTgl;
	sab_pkg::sab_word_t linkRxWord;
	// Toggles back from the link domain
	logic ackA;
	logic ackB;
	logic rxA;
	logic rxB;
	logic rxPrev;
	logic rxArrive;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ackA <= 1'b0;
			ackB <= 1'b0;
			rxA <= 1'b0;
			rxB <= 1'b0;
			rxPrev <= 1'b0;
		end else begin
			ackA <= linkAck;
			ackB <= ackA;
			rxA <= linkRxTgl;
			rxB <= rxA;
			rxPrev <= rxB;
		end
	end
	assign rxArrive = rxB != rxPrev;
	// Transmit side state
	sab_pkg::sab_word_t txHold;
	sab_pkg::sab_word_t txXfer;
	logic txFull;
	logic reqTgl;
	logic txBusy;
	logic handoff;
	logic txFetch;
	logic txLast;
	logic txHalfHit;
	logic txHalfSel;
	logic txAutoOff;
	logic txFromAbu;
	sab_pkg::sab_addr_t txAddr;
	sab_pkg::sab_len_t txCnt;
	sab_pkg::sab_len_t txDone;
	sab_pkg::sab_len_t txLenE;
	assign txBusy = reqTgl != ackB;
	assign handoff = txFull && !txBusy;
	assign txFetch = abuTx && !txFull;
	assign txLenE = lenEff(txLenReg);
	assign txDone = txCnt + 12'h001;
	assign txLast = txDone == txLenE;
	assign txHalfHit = txDone == {1'b0, txLenE[11:1]};
	assign txAutoOff = txFetch && txLast && extReg[`SAB_EXT_ADTX];
	// Receive side state
	sab_pkg::sab_word_t rxDataReg;
	sab_pkg::sab_word_t rxPendWord;
	logic rxFull;
	logic overrun;
	logic rxPend;
	logic rxMemWr;
	logic rxLast;
	logic rxHalfHit;
	logic rxHalfSel;
	logic rxAutoOff;
	sab_pkg::sab_addr_t rxAddr;
	sab_pkg::sab_len_t rxCnt;
	sab_pkg::sab_len_t rxDone;
	sab_pkg::sab_len_t rxLenE;
	assign rxMemWr = rxPend && !cpuMemWr;
	assign rxLenE = lenEff(rxLenReg);
	assign rxDone = rxCnt + 12'h001;
	assign rxLast = rxDone == rxLenE;
	assign rxHalfHit = rxDone == {1'b0, rxLenE[11:1]};
	assign rxAutoOff = rxMemWr && rxLast && extReg[`SAB_EXT_ADRX];
	// Configuration registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrlReg <= `SAB_CTRL_RST;
			extReg <= `SAB_EXT_RST;
			txStartReg <= 11'h000;
			rxStartReg <= 11'h000;
			txLenReg <= `SAB_LEN_RST;
			rxLenReg <= `SAB_LEN_RST;
			clkDivReg <= `SAB_CLKDIV_RST;
			frameReg <= `SAB_FRAME_RST;
		end else begin
			if (regWrite) begin
				if (regAddr == `SAB_REG_CTRL) begin
					ctrlReg <= regWdata[`SAB_CTRL_W-1:0];
				end else if (regAddr == `SAB_REG_EXT) begin
					extReg <= regWdata[`SAB_EXT_W-1:0];
				end else if (regAddr == `SAB_REG_TXSTART) begin
					txStartReg <= regWdata[10:0];
				end else if (regAddr == `SAB_REG_TXLEN) begin
					txLenReg <= regWdata[11:0];
				end else if (regAddr == `SAB_REG_RXSTART) begin
					rxStartReg <= regWdata[10:0];
				end else if (regAddr == `SAB_REG_RXLEN) begin
					rxLenReg <= regWdata[11:0];
				end else if (regAddr == `SAB_REG_CLKDIV) begin
					clkDivReg <= regWdata[7:0];
				end else if (regAddr == `SAB_REG_FRAME) begin
					frameReg <= regWdata[7:0];
				end
			end
			if (txAutoOff) begin
				extReg[`SAB_EXT_ABUTX] <= 1'b0;
			end
			if (rxAutoOff) begin
				extReg[`SAB_EXT_ABURX] <= 1'b0;
			end
		end
	end
	// Transmit address generator, circular
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			txAddr <= 11'h000;
			txCnt <= 12'h000;
			txHalfSel <= 1'b0;
		end else if (!abuTx) begin
			txAddr <= txStartReg;
			txCnt <= 12'h000;
		end else if (txFetch) begin
			if (txLast) begin
				txAddr <= txStartReg;
				txCnt <= 12'h000;
				txHalfSel <= 1'b1;
			end else begin
				txAddr <= txAddr + 11'h001;
				txCnt <= txDone;
			end
			if (txHalfHit) begin
				txHalfSel <= 1'b0;
			end
		end
	end
	// First stage of transmit double buffer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			txHold <= 16'h0000;
			txXfer <= 16'h0000;
			txFull <= 1'b0;
			reqTgl <= 1'b0;
			txFromAbu <= 1'b0;
		end else begin
			if (handoff) begin
				txXfer <= txHold;
				reqTgl <= ~reqTgl;
				txFull <= 1'b0;
			end
			if (txFetch) begin
				txHold <= mem[txAddr];
				txFull <= 1'b1;
				txFromAbu <= 1'b1;
			end else if (wrTxData) begin
				txHold <= regWdata;
				txFull <= 1'b1;
				txFromAbu <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			transmitInterrupt <= 1'b0;
		end else if (abuTx) begin
			transmitInterrupt <= txFetch && (txHalfHit || txLast);
		end else begin
			// Buffered words left over after auto-disable stay silent
			transmitInterrupt <= handoff && !txFromAbu;
		end
	end
	// Receive data register, overrun drops the new word
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rxDataReg <= 16'h0000;
			rxFull <= 1'b0;
			overrun <= 1'b0;
			rxPend <= 1'b0;
			rxPendWord <= 16'h0000;
		end else begin
			if (rdRxData) begin
				rxFull <= 1'b0;
				overrun <= 1'b0;
			end
			if (rxMemWr) begin
				rxPend <= 1'b0;
			end
			if (rxArrive) begin
				if (abuRx) begin
					rxPendWord <= linkRxWord;
					rxPend <= 1'b1;
					if (rxPend && !rxMemWr) begin
						overrun <= 1'b1;
					end
				end else if (rxFull && !rdRxData) begin
					overrun <= 1'b1;
				end else begin
					rxDataReg <= linkRxWord;
					rxFull <= 1'b1;
				end
			end
		end
	end
	// Receive address generator, circular
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rxAddr <= 11'h000;
			rxCnt <= 12'h000;
			rxHalfSel <= 1'b0;
		end else if (!abuRx) begin
			rxAddr <= rxStartReg;
			rxCnt <= 12'h000;
		end else if (rxMemWr) begin
			if (rxLast) begin
				rxAddr <= rxStartReg;
				rxCnt <= 12'h000;
				rxHalfSel <= 1'b1;
			end else begin
				rxAddr <= rxAddr + 11'h001;
				rxCnt <= rxDone;
			end
			if (rxHalfHit) begin
				rxHalfSel <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			receiveInterrupt <= 1'b0;
		end else if (abuRx) begin
			receiveInterrupt <= rxMemWr && (rxHalfHit || rxLast);
		end else begin
			receiveInterrupt <= rxArrive;
		end
	end
	// Shared block; CPU write wins, autobuffer write waits while the CPU writes
	always_ff @(posedge clk_sys) begin
		if (rxMemWr) begin
			mem[rxAddr] <= rxPendWord;
		end else if (cpuMemWr) begin
			mem[memAddrReg] <= regWdata;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			memAddrReg <= 11'h000;
		end else if (regWrite && (regAddr == `SAB_REG_MADDR)) begin
			memAddrReg <= regWdata[10:0];
		end else if (cpuMemWr || cpuMemRd) begin
			memAddrReg <= memAddrReg + 11'h001;
		end
	end
	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= 16'h0000;
		end else begin
			regRdata <= 16'h0000;
			if (regRead) begin
				if (regAddr == `SAB_REG_RXDATA) begin
					regRdata <= abuRx ? 16'h0000 : rxDataReg;
				end else if (regAddr == `SAB_REG_TXDATA) begin
					regRdata <= txHold;
				end else if (regAddr == `SAB_REG_CTRL) begin
					regRdata <= {7'h00, ctrlReg};
				end else if (regAddr == `SAB_REG_EXT) begin
					regRdata <= {12'h000, extReg};
				end else if (regAddr == `SAB_REG_TXSTART) begin
					regRdata <= {5'h00, txStartReg};
				end else if (regAddr == `SAB_REG_TXLEN) begin
					regRdata <= {4'h0, txLenReg};
				end else if (regAddr == `SAB_REG_RXSTART) begin
					regRdata <= {5'h00, rxStartReg};
				end else if (regAddr == `SAB_REG_RXLEN) begin
					regRdata <= {4'h0, rxLenReg};
				end else if (regAddr == `SAB_REG_STATUS) begin
					regRdata <= {10'h000, txBusy, rxHalfSel, txHalfSel, overrun, rxFull, txFull};
				end else if (regAddr == `SAB_REG_MADDR) begin
					regRdata <= {5'h00, memAddrReg};
				end else if (regAddr == `SAB_REG_MDATA) begin
					regRdata <= mem[memAddrReg];
				end else if (regAddr == `SAB_REG_CLKDIV) begin
					regRdata <= {8'h00, clkDivReg};
				end else if (regAddr == `SAB_REG_FRAME) begin
					regRdata <= {8'h00, frameReg};
				end
			end
		end
	end
	// Bit clock divider; half period at least one master cycle
	logic [7:0] divCnt;
	logic clkPhase;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			divCnt <= 8'h00;
			clkPhase <= 1'b0;
			bitClkOut <= 1'b0;
		end else begin
			if (!ctrlReg[`SAB_CTRL_CLKINT]) begin
				divCnt <= 8'h00;
				clkPhase <= 1'b0;
			end else if (divCnt >= clkDivReg) begin
				divCnt <= 8'h00;
				clkPhase <= ~clkPhase;
			end else begin
				divCnt <= divCnt + 8'h01;
			end
			bitClkOut <= clkPhase ^ ctrlReg[`SAB_CTRL_CLKPOL];
		end
	end
	assign bitClkOe = ctrlReg[`SAB_CTRL_CLKINT];
	sab_link uLink (
		.clkLink(clkLink),
		.rst_n(rst_n),
		.cfgLen(ctrlReg[`SAB_CTRL_LEN+1:`SAB_CTRL_LEN]),
		.cfgTxEn(ctrlReg[`SAB_CTRL_TXEN]),
		.cfgRxEn(ctrlReg[`SAB_CTRL_RXEN]),
		.cfgFsInt(ctrlReg[`SAB_CTRL_FSINT]),
		.cfgFsPol(ctrlReg[`SAB_CTRL_FSPOL]),
		.cfgPcm(ctrlReg[`SAB_CTRL_PCM]),
		.cfgFrame(frameReg),
		.txReqTgl(reqTgl),
		.txWord(txXfer),
		.txAckTgl(linkAck),
		.rxTgl(linkRxTgl),
		.rxWord(linkRxWord),
		.fsxIn(fsxIn),
		.fsrIn(fsrIn),
		.rxDataIn(rxDataIn),
		.txData(txData),
		.txDataOe(txDataOe),
		.fsxOut(fsxOut),
		.fsxOe(fsxOe)
	);
endmodule
`default_nettype wire
